// *** logic/ssq_pkg.sv ***
// Package: constants, types and register map of the standby and reset sequencer
package ssq_pkg;
  localparam int unsigned CLK_MHZ          = 20;
  // Operation-stop wait after standby release (microseconds, as printed)
  localparam int unsigned STOP_WAIT_MIN_US = 17;
  localparam int unsigned STOP_WAIT_TYP_US = 34;
  localparam int unsigned STOP_WAIT_MAX_US = 67;
  localparam int unsigned STOP_WAIT_CYC    = STOP_WAIT_TYP_US * CLK_MHZ;
  // Option-byte read after reset release
  localparam int unsigned OPT_READ_TYP_US  = 544;
  localparam int unsigned OPT_READ_MAX_NS  = 1075000;
  localparam int unsigned OPT_READ_CYC     = OPT_READ_TYP_US * CLK_MHZ;
  // Least external reset low time (bound on the other party)
  localparam int unsigned EXT_RST_MIN_US   = 2;
  localparam int unsigned EXT_RST_MIN_CYC  = EXT_RST_MIN_US * CLK_MHZ;
  // Crystal settle exponents for codes 00..11
  localparam int unsigned SETTLE_EXP0      = 10;
  localparam int unsigned SETTLE_EXP1      = 12;
  localparam int unsigned SETTLE_EXP2      = 15;
  localparam int unsigned SETTLE_EXP3      = 17;
  localparam int unsigned CNT_W            = 18;
  // Reset vector addresses
  localparam logic [15:0] RESET_VEC_LO     = 16'h0000;
  localparam logic [15:0] RESET_VEC_HI     = 16'h0001;
  // APB register byte offsets
  localparam logic [7:0]  CTRL_OFS         = 8'h00;
  localparam logic [7:0]  STATUS_OFS       = 8'h04;
  localparam logic [7:0]  IRQ_OFS          = 8'h08;
  // Control register fields
  localparam int unsigned CTRL_SETTLE_LSB  = 0;
  localparam int unsigned CTRL_XTAL_BIT    = 2;
  localparam int unsigned CTRL_LSOFF_BIT   = 3;
  localparam int unsigned CTRL_WDT_LS_BIT  = 4;
  localparam int unsigned CTRL_TMR_LS_BIT  = 5;
  localparam int unsigned CTRL_RSTPORT_BIT = 6;
  localparam logic [6:0]  CTRL_RESET       = 7'h00;
  // Interrupt register fields: mask in [7:0], global enable in [8]
  localparam int unsigned IRQ_GIE_BIT      = 8;
  localparam logic [7:0]  IRQ_MASK_RESET   = 8'hff;

  typedef enum logic [2:0] {
    SSQ_RESET, SSQ_OPT_READ, SSQ_XTAL_SETTLE, SSQ_RUN, SSQ_STANDBY, SSQ_STOP_WAIT
  } ssq_state_e;

  typedef struct packed {
    logic ext_pin_n;
    logic wdt_ovf;
    logic supply_on_clear;
    logic low_supply_detector;
  } ssq_rst_src_s;

  typedef struct packed {
    logic sys_osc_en;
    logic low_speed_osc_en;
    logic cpu_run;
    logic aux_timer_run;
    logic wdt_run;
    logic timer16_run;
    logic adc_run;
  } ssq_gate_s;
endpackage : ssq_pkg

// *** logic/ssq_wait_counter.sv ***
// Down counter that times one wait and pulses when it ends
`timescale 1ns/1ps
module ssq_wait_counter
  import ssq_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Status
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_busy;
  logic         next_done;

  always_comb begin
    next_cnt  = cnt;
    next_busy = busy;
    next_done = 1'b0;
    if (load) begin
      next_cnt  = load_val;
      next_busy = 1'b1;
    end else if (busy) begin
      if (cnt <= W'(1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_cnt  = '0;
      end else begin
        next_cnt = cnt - W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end
endmodule : ssq_wait_counter

// *** logic/ssq_sequencer.sv ***
// Standby and reset sequencer with APB register access
`timescale 1ns/1ps
// Summary of operation
// - Stop instruction enters deep standby
// - Pending unmasked request leaves standby at once
// - Hold stopped 34 us after standby release, or the crystal settle time instead if crystal selected
// - Standby stops oscillator, CPU; ports hold
// - Aux timer on prescaled clock stops
// - Aux timer on low-speed clock runs if oscillating
// - Low-speed watchdog runs if oscillating; system-clock watchdog stops
// - Reset-time option picks low-speed oscillator stoppable
// - Wake: vector, next instruction, or stay
// - Reset in standby releases, then settle
// - Option byte read 544 us before CPU
// - Four reset sources merged into one
// - All sources equal; start at vector 0000H/0001H
// - Pins float in reset; indicator drives low
// - Low pin resets; high releases after option read
// - Watchdog reset self-releases, then start-up
// - Supply resets release when supply recovers
// - Reset stops both oscillators
// - Port-mode pin low before option read resets
// - Low-supply detector ignores its own reset
// - Settle codes give 2^10,2^12,2^15,2^17 clocks
module ssq_sequencer
  import ssq_pkg::*;
#(
  parameter int unsigned OPT_READ_CYCLES = OPT_READ_CYC,
  parameter int unsigned NUM_IRQ         = 8
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Reset sources and option
  input  wire ssq_rst_src_s       rst_src,
  input  wire logic               opt_ls_stoppable,
  // CPU and interrupts
  input  wire logic               stop_exec,
  input  wire logic [NUM_IRQ-1:0] irq_req,
  output logic                    wake_vector,
  output logic                    wake_next,
  output logic [15:0]             vector_fetch_addr,
  output logic                    sys_reset_n,
  output logic                    lsd_reset_n,
  // Block gating
  output ssq_gate_s               gate,
  output logic                    port_hold,
  output logic                    pins_float,
  // Reset indicator pin
  output logic                    reset_indicator_pin_o,
  output logic                    reset_indicator_pin_oe_n
);
  ssq_state_e   state;
  ssq_state_e   next_state;
  logic [6:0]   ctrl;
  logic [6:0]   next_ctrl;
  logic [7:0]   interrupt_mask_flag;
  logic [7:0]   next_interrupt_mask_flag;
  logic         global_interrupt_enable;
  logic         next_global_interrupt_enable;
  logic         ls_stoppable;
  logic         next_ls_stoppable;
  logic         wake_is_reset;
  logic         next_wake_is_reset;
  logic         wake_vec_pend;
  logic         next_wake_vec_pend;
  logic         wake_vector_r;
  logic         next_wake_vector;
  logic         wake_next_r;
  logic         next_wake_next;
  logic [31:0]  prdata_r;
  logic [31:0]  next_prdata;
  logic         cnt_load;
  logic [CNT_W-1:0] cnt_val;
  logic         cnt_busy;
  logic         cnt_done;
  logic         any_reset;
  logic         unmasked;
  logic         ls_running;
  logic [1:0]   osc_settle_select;
  logic         xtal_sel;
  logic         apb_wr;
  logic         apb_rd;
  logic [CNT_W-1:0] settle_cyc;

  assign osc_settle_select = ctrl[CTRL_SETTLE_LSB +: 2];
  assign xtal_sel          = ctrl[CTRL_XTAL_BIT];

  // Crystal settle length from the select field
  always_comb begin
    case (osc_settle_select)
      2'b00:   settle_cyc = CNT_W'(1 << SETTLE_EXP0);
      2'b01:   settle_cyc = CNT_W'(1 << SETTLE_EXP1);
      2'b10:   settle_cyc = CNT_W'(1 << SETTLE_EXP2);
      default: settle_cyc = CNT_W'(1 << SETTLE_EXP3);
    endcase
  end

  // Merged reset, with pin used as port after the option read
  always_comb begin
    any_reset = !rst_src.ext_pin_n || rst_src.wdt_ovf
             || rst_src.supply_on_clear || rst_src.low_supply_detector;
    if (ctrl[CTRL_RSTPORT_BIT] && state != SSQ_OPT_READ && state != SSQ_RESET)
      any_reset = rst_src.wdt_ovf || rst_src.supply_on_clear
               || rst_src.low_supply_detector;
  end

  assign unmasked = |(irq_req & ~interrupt_mask_flag[NUM_IRQ-1:0]);
  assign apb_wr   = psel && penable && pwrite;
  assign apb_rd   = psel && penable && !pwrite;

  ssq_wait_counter #(.W(CNT_W)) u_wait (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (cnt_load),
    .load_val (cnt_val),
    .busy     (cnt_busy),
    .done     (cnt_done)
  );

  // Sequencer next state
  always_comb begin
    next_state         = state;
    next_wake_is_reset = wake_is_reset;
    next_wake_vec_pend = wake_vec_pend;
    next_wake_vector   = 1'b0;
    next_wake_next     = 1'b0;
    next_ls_stoppable  = ls_stoppable;
    cnt_load           = 1'b0;
    cnt_val            = '0;
    if (any_reset && state != SSQ_STANDBY
        && !(state == SSQ_STOP_WAIT && wake_is_reset)) begin
      next_state = SSQ_RESET;
    end else begin
      case (state)
        SSQ_RESET: begin
          next_state = SSQ_OPT_READ;
          cnt_load   = 1'b1;
          cnt_val    = CNT_W'(OPT_READ_CYCLES);
        end
        SSQ_OPT_READ: if (cnt_done) begin
          next_ls_stoppable = opt_ls_stoppable;
          if (xtal_sel) begin
            next_state = SSQ_XTAL_SETTLE;
            cnt_load   = 1'b1;
            cnt_val    = settle_cyc;
          end else begin
            next_state = SSQ_RUN;
          end
        end
        SSQ_XTAL_SETTLE: if (cnt_done) next_state = SSQ_RUN;
        SSQ_RUN: if (stop_exec) begin
          if (unmasked) begin
            next_wake_vector = global_interrupt_enable;
            next_wake_next   = !global_interrupt_enable;
          end else begin
            next_state = SSQ_STANDBY;
          end
        end
        SSQ_STANDBY: if (any_reset || unmasked) begin
          next_wake_is_reset = any_reset;
          next_wake_vec_pend = global_interrupt_enable;
          next_state         = SSQ_STOP_WAIT;
          cnt_load           = 1'b1;
          cnt_val            = xtal_sel ? settle_cyc : CNT_W'(STOP_WAIT_CYC);
        end
        SSQ_STOP_WAIT: if (cnt_done) begin
          if (wake_is_reset) begin
            next_state = SSQ_RESET;
          end else begin
            next_state       = SSQ_RUN;
            next_wake_vector = wake_vec_pend;
            next_wake_next   = !wake_vec_pend;
          end
        end
        default: next_state = SSQ_RESET;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= SSQ_RESET;
      wake_is_reset <= 1'b0;
      wake_vec_pend <= 1'b0;
      wake_vector_r <= 1'b0;
      wake_next_r   <= 1'b0;
      ls_stoppable  <= 1'b0;
    end else begin
      state         <= next_state;
      wake_is_reset <= next_wake_is_reset;
      wake_vec_pend <= next_wake_vec_pend;
      wake_vector_r <= next_wake_vector;
      wake_next_r   <= next_wake_next;
      ls_stoppable  <= next_ls_stoppable;
    end
  end

  assign wake_vector = wake_vector_r;
  assign wake_next   = wake_next_r;

  // Register next values
  always_comb begin
    next_ctrl                    = ctrl;
    next_interrupt_mask_flag     = interrupt_mask_flag;
    next_global_interrupt_enable = global_interrupt_enable;
    next_prdata                  = prdata_r;
    if (apb_wr && paddr == CTRL_OFS) begin
      next_ctrl = pwdata[6:0];
      if (!ls_stoppable)
        next_ctrl[CTRL_LSOFF_BIT] = 1'b0;
      if (!ls_stoppable && !pwdata[CTRL_WDT_LS_BIT])
        next_ctrl[CTRL_WDT_LS_BIT] = 1'b1;
    end
    if (apb_wr && paddr == IRQ_OFS) begin
      next_interrupt_mask_flag     = pwdata[7:0];
      next_global_interrupt_enable = pwdata[IRQ_GIE_BIT];
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        CTRL_OFS:   next_prdata = {25'h0, ctrl};
        STATUS_OFS: next_prdata = {24'h0, ls_stoppable, cnt_busy, unmasked,
                                   any_reset, 1'b0, state};
        IRQ_OFS:    next_prdata = {23'h0, global_interrupt_enable, interrupt_mask_flag};
        default:    next_prdata = 32'h0;
      endcase
    end
    if (state == SSQ_RESET) begin
      next_ctrl                    = CTRL_RESET;
      next_interrupt_mask_flag     = IRQ_MASK_RESET;
      next_global_interrupt_enable = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl                    <= CTRL_RESET;
      interrupt_mask_flag     <= IRQ_MASK_RESET;
      global_interrupt_enable <= 1'b0;
      prdata_r                <= 32'h0;
    end else begin
      ctrl                    <= next_ctrl;
      interrupt_mask_flag     <= next_interrupt_mask_flag;
      global_interrupt_enable <= next_global_interrupt_enable;
      prdata_r                <= next_prdata;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && paddr != CTRL_OFS && paddr != STATUS_OFS
                && paddr != IRQ_OFS;

  // Clock and block gating
  assign ls_running = !(ls_stoppable && ctrl[CTRL_LSOFF_BIT]) && state != SSQ_RESET;
  always_comb begin
    gate.sys_osc_en       = state != SSQ_RESET && state != SSQ_STANDBY;
    gate.low_speed_osc_en = ls_running;
    gate.cpu_run          = state == SSQ_RUN;
    gate.aux_timer_run    = state == SSQ_STANDBY ?
                            (ctrl[CTRL_TMR_LS_BIT] && ls_running) : 1'b1;
    gate.wdt_run          = state == SSQ_STANDBY ?
                            (ctrl[CTRL_WDT_LS_BIT] && ls_running) : 1'b1;
    gate.timer16_run      = state != SSQ_STANDBY;
    gate.adc_run          = state != SSQ_STANDBY;
  end

  assign port_hold                = state == SSQ_STANDBY || state == SSQ_STOP_WAIT;
  assign pins_float               = state == SSQ_RESET || state == SSQ_OPT_READ
                                 || state == SSQ_XTAL_SETTLE;
  assign reset_indicator_pin_o    = 1'b0;
  assign reset_indicator_pin_oe_n = !pins_float;
  assign vector_fetch_addr        = RESET_VEC_LO;
  assign sys_reset_n              = !(state == SSQ_RESET);
  assign lsd_reset_n              = !(rst_src.ext_pin_n == 1'b0 || rst_src.wdt_ovf
                                   || rst_src.supply_on_clear);

  // Assertions
  property p_stop_enter;
    @(posedge pclk) disable iff (!presetn)
      state == SSQ_RUN && stop_exec && !unmasked && !any_reset |=> state == SSQ_STANDBY;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop not entered");

  property p_pend_wake;
    @(posedge pclk) disable iff (!presetn)
      state == SSQ_RUN && stop_exec && unmasked && !any_reset |=> state == SSQ_RUN;
  endproperty
  a_pend_wake: assert property (p_pend_wake) else $error("pending request ignored");

  property p_stop_wait;
    @(posedge pclk) disable iff (!presetn)
      state == SSQ_STANDBY && unmasked && !any_reset && !xtal_sel
      |=> state == SSQ_STOP_WAIT [*8];
  endproperty
  a_stop_wait: assert property (p_stop_wait) else $error("stop wait too short");

  property p_osc_off;
    @(posedge pclk) disable iff (!presetn)
      state == SSQ_STANDBY |-> !gate.sys_osc_en && !gate.cpu_run && port_hold;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator runs in standby");

  property p_rst_float;
    @(posedge pclk) disable iff (!presetn)
      state == SSQ_RESET |-> pins_float && !reset_indicator_pin_oe_n
                             && !reset_indicator_pin_o;
  endproperty
  a_rst_float: assert property (p_rst_float) else $error("pins not floated");

  sequence s_reset_seen;
    state == SSQ_RESET && !any_reset;
  endsequence
  property p_opt_read;
    @(posedge pclk) disable iff (!presetn)
      s_reset_seen |=> state == SSQ_OPT_READ && !gate.cpu_run;
  endproperty
  a_opt_read: assert property (p_opt_read) else $error("option read skipped");

  property p_merge;
    @(posedge pclk) disable iff (!presetn)
      state != SSQ_STANDBY && !(state == SSQ_STOP_WAIT && wake_is_reset)
      && (rst_src.wdt_ovf || rst_src.supply_on_clear) |=> state == SSQ_RESET;
  endproperty
  a_merge: assert property (p_merge) else $error("reset source ignored");

  property p_rst_osc;
    @(posedge pclk) disable iff (!presetn)
      state == SSQ_RESET |-> !gate.sys_osc_en && !gate.low_speed_osc_en;
  endproperty
  a_rst_osc: assert property (p_rst_osc) else $error("oscillator runs in reset");

  property p_lsd_self;
    @(posedge pclk) disable iff (!presetn)
      rst_src.low_supply_detector && rst_src.ext_pin_n && !rst_src.wdt_ovf
      && !rst_src.supply_on_clear |-> lsd_reset_n;
  endproperty
  a_lsd_self: assert property (p_lsd_self) else $error("detector reset itself");

  property p_standby_gate;
    @(posedge pclk) disable iff (!presetn)
      state == SSQ_STANDBY |-> !gate.timer16_run && !gate.adc_run
                               && (gate.aux_timer_run == (ctrl[CTRL_TMR_LS_BIT] && ls_running));
  endproperty
  a_standby_gate: assert property (p_standby_gate) else $error("standby gating wrong");
endmodule : ssq_sequencer

// *** tb/ssq_cpu_model.sv ***
// Behavioural CPU core, interrupt sources and reset inputs facing the sequencer
`timescale 1ns/1ps
module ssq_cpu_model
  import ssq_pkg::*;
(
  // Clock
  input  wire logic    pclk,
  // Toward the sequencer
  output ssq_rst_src_s rst_src,
  output logic [7:0]   irq_req,
  output logic         stop_exec
);
  initial begin
    rst_src   = ssq_rst_src_s'(4'b1000);
    irq_req   = 8'h00;
    stop_exec = 1'b0;
  end

  // One-cycle stop instruction
  task issue_stop();
    @(posedge pclk);
    stop_exec <= 1'b1;
    @(posedge pclk);
    stop_exec <= 1'b0;
  endtask : issue_stop

  task set_irq(input logic [7:0] v);
    @(posedge pclk);
    irq_req <= v;
  endtask : set_irq

  // Source 0 pin (active low), 1 watchdog, 2 supply-on-clear, 3 detector
  task assert_reset(input int src);
    @(posedge pclk);
    rst_src <= ssq_rst_src_s'(4'b1000 ^ (4'b1000 >> src));
  endtask : assert_reset

  // Never release before the least low time of the pin
  task release_reset();
    repeat (EXT_RST_MIN_CYC) @(posedge pclk);
    rst_src <= ssq_rst_src_s'(4'b1000);
  endtask : release_reset
endmodule : ssq_cpu_model

// *** tb/tb_ssq_sequencer.sv ***
// Self-checking bench of the standby and reset sequencer
`timescale 1ns/1ps
module tb_ssq_sequencer
  import ssq_pkg::*;
;
  localparam int OPT_RD = 20;
  logic         pclk       = 1'b0;
  logic         presetn    = 1'b0;
  logic         psel       = 1'b0;
  logic         penable    = 1'b0;
  logic         pwrite     = 1'b0;
  logic [7:0]   paddr      = 8'h00;
  logic [31:0]  pwdata     = 32'h0;
  logic         opt_ls     = 1'b1;
  logic [15:0]  lfsr       = 16'h5a02;
  int           n_mismatch = 0;
  int           tests_run  = 0;
  logic [31:0]  prdata;
  logic         pready, pslverr, wake_vector, wake_next, sys_reset_n, lsd_reset_n;
  logic         port_hold, pins_float, ind_o, ind_oe_n, stop_exec;
  logic [15:0]  vec_addr;
  logic [7:0]   irq_req;
  ssq_rst_src_s rst_src;
  ssq_gate_s    gate;
  wire  [4:0]   mon = {gate.cpu_run, wake_vector, wake_next, sys_reset_n, gate.sys_osc_en};

  always #25 pclk = ~pclk;

  ssq_cpu_model ssq_cpu_model_i (.pclk(pclk), .rst_src(rst_src), .irq_req(irq_req),
    .stop_exec(stop_exec));

  ssq_sequencer #(.OPT_READ_CYCLES(OPT_RD), .NUM_IRQ(8)) ssq_sequencer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rst_src(rst_src), .opt_ls_stoppable(opt_ls), .stop_exec(stop_exec),
    .irq_req(irq_req), .wake_vector(wake_vector), .wake_next(wake_next),
    .vector_fetch_addr(vec_addr), .sys_reset_n(sys_reset_n), .lsd_reset_n(lsd_reset_n),
    .gate(gate), .port_hold(port_hold), .pins_float(pins_float),
    .reset_indicator_pin_o(ind_o), .reset_indicator_pin_oe_n(ind_oe_n));

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step

  // Wake wait: crystal settle when a crystal is selected, else the fixed stop wait
  function automatic int exp_wait(input logic [6:0] c);
    int e [4];
    e = '{SETTLE_EXP0, SETTLE_EXP1, SETTLE_EXP2, SETTLE_EXP3};
    return c[CTRL_XTAL_BIT] ? (1 << e[c[1:0]]) : int'(STOP_WAIT_CYC);
  endfunction : exp_wait

  task complete_run();
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task timeout();
    n_mismatch++;
    $display("wrong value at %0t: wait ran out, got %h expected %h", $time, mon, 5'h1f);
    complete_run();
  endtask : timeout

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) timeout();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Counts falling edges until a monitored output takes the value
  task wait_bit(input int idx, input logic v, input int lim, output int n);
    n = 0;
    @(negedge pclk);
    while (mon[idx] !== v) begin
      if (n >= lim) timeout();
      n++;
      @(negedge pclk);
    end
  endtask : wait_bit

  initial begin
    logic [31:0] rd;
    logic        err;
    logic [6:0]  c;
    logic [7:0]  m;
    logic [6:0]  ctab [6];
    int          n, k, j, w;
    ctab = '{7'h00, 7'h30, 7'h38, 7'h04, 7'h05, 7'h06};
    repeat (20) @(posedge pclk);
    chk({pins_float, ind_oe_n}, 2'b10);
    chk({gate.sys_osc_en, gate.low_speed_osc_en}, 2'b00);
    presetn <= 1'b1;
    wait_bit(4, 1'b1, OPT_RD + 20, n);
    chk(n >= OPT_RD && n <= OPT_RD + 4, 1'b1);
    chk(vec_addr, RESET_VEC_LO);
    apb(1'b1, 8'h10, 32'hffffffff, rd, err);
    chk(err, 1'b1);
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0, rd, err);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      c = ctab[i];
      lfsr = lfsr_step(lfsr);
      k = lfsr[2:0];
      j = (k + 1) % 8;
      m = (lfsr[15:8] | (8'h01 << j)) & ~(8'h01 << k);
      apb(1'b1, CTRL_OFS, {25'h0, c}, rd, err);
      apb(1'b1, IRQ_OFS, {23'h0, i[0], m}, rd, err);
      ssq_cpu_model_i.issue_stop();
      repeat (2) @(negedge pclk);
      chk({gate.cpu_run, gate.sys_osc_en, port_hold}, 3'b001);
      chk({gate.timer16_run, gate.adc_run}, 2'b00);
      chk(gate.aux_timer_run, c[5] & ~c[3]);
      chk({gate.wdt_run, gate.low_speed_osc_en}, {c[4] & ~c[3], ~c[3]});
      ssq_cpu_model_i.set_irq(8'h01 << j);
      repeat (10) @(negedge pclk);
      chk(gate.cpu_run, 1'b0);
      ssq_cpu_model_i.set_irq((8'h01 << j) | (8'h01 << k));
      w = exp_wait(c);
      wait_bit(i[0] ? 3 : 2, 1'b1, w + 8, n);
      chk(n >= w && n <= w + 4, 1'b1);
      chk(i[0] ? wake_next : wake_vector, 1'b0);
      ssq_cpu_model_i.set_irq(8'h00);
    end
    apb(1'b1, IRQ_OFS, 32'h0fe, rd, err);
    ssq_cpu_model_i.set_irq(8'h01);
    ssq_cpu_model_i.issue_stop();
    wait_bit(2, 1'b1, 3, n);
    chk(gate.cpu_run, 1'b1);
    ssq_cpu_model_i.set_irq(8'h00);
    for (int s = 0; s < 4; s++) begin
      @(posedge pclk);
      opt_ls <= (s != 3);
      ssq_cpu_model_i.assert_reset(s);
      repeat (3) @(negedge pclk);
      chk({sys_reset_n, lsd_reset_n}, {1'b0, s == 3});
      chk({pins_float, ind_oe_n, ind_o}, 3'b100);
      chk({gate.sys_osc_en, gate.low_speed_osc_en, gate.cpu_run}, 3'b000);
      ssq_cpu_model_i.release_reset();
      wait_bit(4, 1'b1, OPT_RD + 20, n);
      chk(n >= OPT_RD && n <= OPT_RD + 4, 1'b1);
      apb(1'b0, STATUS_OFS, 32'h0, rd, err);
      chk(rd[7], s != 3);
      apb(1'b0, IRQ_OFS, 32'h0, rd, err);
      chk(rd, {24'h0, IRQ_MASK_RESET});
    end
    apb(1'b1, CTRL_OFS, 32'h40, rd, err);
    ssq_cpu_model_i.assert_reset(0);
    repeat (3) @(negedge pclk);
    chk({sys_reset_n, gate.cpu_run}, 2'b11);
    ssq_cpu_model_i.release_reset();
    apb(1'b1, CTRL_OFS, 32'h08, rd, err);
    ssq_cpu_model_i.issue_stop();
    repeat (2) @(negedge pclk);
    chk({gate.low_speed_osc_en, gate.wdt_run}, 2'b11);
    ssq_cpu_model_i.assert_reset(0);
    wait_bit(1, 1'b0, STOP_WAIT_CYC + 8, n);
    chk(n >= STOP_WAIT_CYC - 1, 1'b1);
    ssq_cpu_model_i.release_reset();
    wait_bit(4, 1'b1, OPT_RD + 80, n);
    chk(gate.cpu_run, 1'b1);
    complete_run();
  end
endmodule : tb_ssq_sequencer
